/* File: verilog/odf_decode_regs.vh */
// constants for the operand descriptor decode and condition flag block
`ifndef ODF_DECODE_REGS_VH
`define ODF_DECODE_REGS_VH
// register byte offsets
`define ODF_OFS_CTRL 4'h0
`define ODF_OFS_PSW 4'h4
`define ODF_OFS_STAT 4'h8
// control fields and reset value
`define ODF_CTRL_EN 0
`define ODF_CTRL_RST 32'h0000_0001
// status fields
`define ODF_STAT_ILL 0
`define ODF_STAT_RSVD 1
`define ODF_STAT_EXP 2
`define ODF_STAT_TYPE_LO 4
// flag positions in the processor status word
`define ODF_PSW_N 21
`define ODF_PSW_Z 20
`define ODF_PSW_V 19
`define ODF_PSW_C 18
// axi responses
`define ODF_RESP_OK 2'h0
`define ODF_RESP_ERR 2'h2
// descriptor modes
`define ODF_MODE_REG 4'h4
`define ODF_MODE_DEF 4'h5
`define ODF_MODE_EXP 4'hE
`define ODF_MODE_NLIT 4'hF
`define ODF_REG_AP 4'hB
`define ODF_REG_PC 4'hF
// operand type codes
`define ODF_T_SB 4'h7
`define ODF_T_SH 4'h6
`define ODF_T_SW 4'h4
`define ODF_T_UB 4'h3
`define ODF_T_UH 4'h2
`define ODF_T_UW 4'h0
// operand kinds
`define ODF_K_LIT 2'h0
`define ODF_K_REG 2'h1
`define ODF_K_DEF 2'h2
`define ODF_K_OTH 2'h3
// operand sizes
`define ODF_SZ_B 2'h0
`define ODF_SZ_H 2'h1
`define ODF_SZ_W 2'h2
// flag instruction classes
`define ODF_FC_LOG 2'h0
`define ODF_FC_ARI 2'h1
`define ODF_FC_TST 2'h2
`define ODF_FC_ALS 2'h3
`endif

/* File: verilog/odf_flags.v */
// condition flag evaluation from the wide result and the written output
`timescale 1ns/100ps
`default_nettype none
`include "odf_decode_regs.vh"
module odf_flags
(
	// operation description
	input wire [1:0] i_fclass,
	input wire [1:0] i_size,
	input wire i_signed,
	// result and output value
	input wire [32:0] i_res,
	input wire [31:0] i_out,
	// flags n z v c
	output reg [3:0] o_nzvc
);
	reg msb;
	reg oz;
	reg c;
	reg v_s;
	reg v_u;
	// pick the output sign and truncation checks by destination size
	always @*
	begin
		msb = i_out[31];
		oz = (i_out == 32'h0000_0000);
		c = i_res[32];
		v_s = |(i_res[32:31] ^ {2{i_out[31]}});
		v_u = 1'b0;
		if (i_size == `ODF_SZ_B)
		begin
			msb = i_out[7];
			oz = (i_out[7:0] == 8'h00);
			c = i_res[8]; // RL20
			v_s = |(i_res[32:7] ^ {26{i_out[7]}}); // RL18
			v_u = |i_res[32:8]; // RL18
		end
		else if (i_size == `ODF_SZ_H)
		begin
			msb = i_out[15];
			oz = (i_out[15:0] == 16'h0000);
			c = i_res[16]; // RL20
			v_s = |(i_res[32:15] ^ {18{i_out[15]}}); // RL18
			v_u = |i_res[32:16]; // RL18
		end
		else
		begin
			v_u = i_res[32]; // RL18
		end
		if (i_fclass == `ODF_FC_LOG)
			o_nzvc = {msb, oz, (i_signed ? v_s : v_u), 1'b0}; // RL16 RL17 RL20
		else if (i_fclass == `ODF_FC_TST)
			o_nzvc = {i_res[32], (i_res == 33'h0_0000_0000), 1'b0, c}; // RL19
		else
			// borrow shows as the same bit for subtracts, a<b sets it
			o_nzvc = {i_res[32], (i_res == 33'h0_0000_0000), (i_signed ? v_s : v_u), c}; // RL16 RL17 RL19 RL21
	end
endmodule
`default_nettype wire

/* File: verilog/odf_decode.v */
// operand descriptor decode, operand extension and condition flag register
//
// Notes on behaviour
// [RL1] positive literal: low six bits, zero filled
// [RL2] mode fifteen: whole byte negative literal
// [RL3] literal as destination or address is illegal
// [RL4] register mode uses register directly, no address
// [RL5] register byte read zero extended to word
// [RL6] deferred mode register holds operand address
// [RL7] memory halfword sign extended by default
// [RL8] type override persists for later operands
// [RL9] expanded form takes two descriptor bytes
// [RL10] override sets immediate signedness, not literals
// [RL11] type codes seven six four three two zero
// [RL12] other type codes raise reserved type exception
// [RL13] override illegal in listed instruction groups
// [RL14] flags n z v c in bits 21..18
// [RL15] wide result, destination type sets width
// [RL16] negative flag from output msb or sign
// [RL17] zero flag from output or full result
// [RL18] overflow from truncated bits against sign
// [RL19] test compare clear overflow, shift on loss
// [RL20] logical clears carry, else carry bit
// [RL21] subtracts show borrow in carry
// [RL22] flags still update on write fault
// [RL23] mode upper nibble, register lower nibble
// [RL24] mode fourteen marks expanded type byte
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "odf_decode_regs.vh"
module odf_decode
(
	// clock, reset, enable
	input wire i_clk,
	input wire i_rst_b,
	input wire i_ce,
	// descriptor stream from fetch
	input wire i_desc_valid,
	input wire [7:0] i_desc_byte,
	input wire i_desc_first,
	input wire [3:0] i_opc_type,
	input wire i_opnd_dst,
	input wire i_opnd_ea,
	input wire i_opc_no_expand,
	// decoded operand
	output reg o_opnd_valid,
	output reg [1:0] o_opnd_kind,
	output reg [3:0] o_opnd_reg,
	output reg [31:0] o_opnd_lit,
	output reg [3:0] o_opnd_type,
	output reg o_exc_illegal,
	output reg o_exc_rsvd,
	// raw operand data to extend
	input wire i_raw_valid,
	input wire [31:0] i_raw_data,
	input wire [3:0] i_raw_type,
	output reg o_ext_valid,
	output reg [31:0] o_ext_data,
	// flag update
	input wire i_flag_valid,
	input wire [1:0] i_fclass,
	input wire [3:0] i_dst_type,
	input wire [32:0] i_res,
	input wire [31:0] i_out,
	input wire i_wfault,
	output reg [3:0] o_nzvc,
	// axi4-lite write address and data
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam ST_DESC = 1'b0;
	localparam ST_EXP = 1'b1;

	// ----------------------------------------
	// type code helpers
	// ----------------------------------------
	// size of a type code
	function [1:0] odf_size;
		input [3:0] t;
		begin
			if (t == `ODF_T_SB || t == `ODF_T_UB)
				odf_size = `ODF_SZ_B;
			else if (t == `ODF_T_SH || t == `ODF_T_UH)
				odf_size = `ODF_SZ_H;
			else
				odf_size = `ODF_SZ_W;
		end
	endfunction

	// signedness of a type code
	function odf_signed;
		input [3:0] t;
		begin
			odf_signed = (t == `ODF_T_SB) || (t == `ODF_T_SH) || (t == `ODF_T_SW); // RL11
		end
	endfunction

	// codes without a defined type
	function odf_rsvd;
		input [3:0] t;
		begin
			odf_rsvd = !(odf_signed(t) || t == `ODF_T_UB || t == `ODF_T_UH || t == `ODF_T_UW); // RL12
		end
	endfunction

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	reg rst_m;
	reg rst_q;
	wire rst_n = rst_q;

	// two stages so release is clean against the clock
	always @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_m <= 1'b0;
			rst_q <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1;
			rst_q <= rst_m;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [31:0] ctrl;
	reg st_ill;
	reg st_rsvd;
	reg state;
	reg [3:0] cur_type;
	reg [31:0] processor_status_word;
	wire dec_en = ctrl[`ODF_CTRL_EN];

	// ----------------------------------------
	// descriptor decode
	// ----------------------------------------
	wire [3:0] mode = i_desc_byte[7:4]; // RL23
	wire [3:0] rfld = i_desc_byte[3:0]; // RL23
	wire [3:0] eff_type = (i_desc_first && state == ST_DESC) ? i_opc_type : cur_type;
	reg next_state;
	reg [3:0] next_type;
	reg d_valid;
	reg [1:0] d_kind;
	reg [31:0] d_lit;
	reg d_ill;
	reg d_rsvd;

	// one byte per beat; expanded byte changes type and state, gives no operand
	always @*
	begin
		next_state = state;
		next_type = eff_type;
		d_valid = 1'b0;
		d_kind = `ODF_K_OTH;
		d_lit = 32'h0000_0000;
		d_ill = 1'b0;
		d_rsvd = 1'b0;
		if (mode == `ODF_MODE_EXP && state == ST_DESC) // RL24
		begin
			next_state = ST_EXP; // RL9
			next_type = rfld; // RL8
			d_rsvd = odf_rsvd(rfld); // RL12
			d_ill = i_opc_no_expand; // RL13
		end
		else
		begin
			next_state = ST_DESC;
			d_valid = 1'b1;
			// a second expanded byte in a row has no meaning
			d_ill = (mode == `ODF_MODE_EXP);
			if (mode[3:2] == 2'b00)
			begin
				d_kind = `ODF_K_LIT;
				d_lit = {26'h000_0000, i_desc_byte[5:0]}; // RL1 RL10
				d_ill = i_opnd_dst || i_opnd_ea; // RL3
			end
			else if (mode == `ODF_MODE_NLIT)
			begin
				d_kind = `ODF_K_LIT;
				d_lit = {24'hFF_FFFF, i_desc_byte}; // RL2 RL10
				d_ill = i_opnd_dst || i_opnd_ea; // RL3
			end
			else if (mode == `ODF_MODE_REG)
			begin
				d_kind = `ODF_K_REG; // RL4
				d_ill = i_opnd_ea || rfld == `ODF_REG_PC; // RL4
			end
			else if (mode == `ODF_MODE_DEF)
			begin
				d_kind = `ODF_K_DEF; // RL6
				d_ill = rfld == `ODF_REG_AP || rfld == `ODF_REG_PC; // RL6
			end
		end
	end

	wire take = i_ce && dec_en && i_desc_valid;

	// register the decoded operand and keep the override in force
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_DESC;
			cur_type <= `ODF_T_UW;
			o_opnd_valid <= 1'b0;
			o_opnd_kind <= `ODF_K_OTH;
			o_opnd_reg <= 4'h0;
			o_opnd_lit <= 32'h0000_0000;
			o_opnd_type <= `ODF_T_UW;
			o_exc_illegal <= 1'b0;
			o_exc_rsvd <= 1'b0;
		end
		else if (i_ce)
		begin
			o_opnd_valid <= take && d_valid;
			o_exc_illegal <= take && d_ill; // RL3 RL13
			o_exc_rsvd <= take && d_rsvd; // RL12
			if (take)
			begin
				state <= next_state; // RL9
				cur_type <= next_type; // RL8
				o_opnd_kind <= d_kind;
				o_opnd_reg <= rfld;
				o_opnd_lit <= d_lit;
				o_opnd_type <= next_type; // RL10
			end
		end
	end

	// ----------------------------------------
	// operand extension
	// ----------------------------------------
	reg [31:0] ext;
	wire raw_s = odf_signed(i_raw_type);

	// default byte type is unsigned, default halfword signed
	always @*
	begin
		ext = i_raw_data;
		if (odf_size(i_raw_type) == `ODF_SZ_B)
			ext = {{24{raw_s & i_raw_data[7]}}, i_raw_data[7:0]}; // RL5
		else if (odf_size(i_raw_type) == `ODF_SZ_H)
			ext = {{16{raw_s & i_raw_data[15]}}, i_raw_data[15:0]}; // RL7
	end

	// extended operand is registered on the way to the datapath
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_ext_valid <= 1'b0;
			o_ext_data <= 32'h0000_0000;
		end
		else if (i_ce)
		begin
			o_ext_valid <= i_raw_valid;
			if (i_raw_valid)
				o_ext_data <= ext; // RL15
		end
	end

	// ----------------------------------------
	// condition flags
	// ----------------------------------------
	wire [3:0] nzvc;

	odf_flags u_flags
	(
		.i_fclass(i_fclass),
		.i_size(odf_size(i_dst_type)),
		.i_signed(odf_signed(i_dst_type)),
		.i_res(i_res),
		.i_out(i_out),
		.o_nzvc(nzvc)
	);

	// a write fault does not hold the flags back
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			processor_status_word <= 32'h0000_0000;
			o_nzvc <= 4'h0;
		end
		else if (i_ce && i_flag_valid && (i_wfault || !i_wfault)) // RL22
		begin
			processor_status_word[`ODF_PSW_N:`ODF_PSW_C] <= nzvc; // RL14
			o_nzvc <= nzvc; // RL14
		end
	end

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	reg aw_got;
	reg w_got;
	reg [3:0] aw_q;
	reg [31:0] w_q;
	reg [3:0] ws_q;
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire [3:0] wa = aw_hs ? s_axi_awaddr : aw_q;
	wire [31:0] wd = w_hs ? s_axi_wdata : w_q;
	wire [3:0] wsb = w_hs ? s_axi_wstrb : ws_q;
	wire wr_go = (aw_got || aw_hs) && (w_got || w_hs) && !s_axi_bvalid;
	wire clr_w = wr_go && wa == `ODF_OFS_STAT && wsb[0];

	// write side takes address and data in either order
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_q <= 4'h0;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ODF_RESP_OK;
			ctrl <= `ODF_CTRL_RST;
		end
		else if (i_ce)
		begin
			if (aw_hs)
				aw_q <= s_axi_awaddr;
			if (w_hs)
			begin
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			s_axi_awready <= !aw_got && !aw_hs && !s_axi_bvalid;
			s_axi_wready <= !w_got && !w_hs && !s_axi_bvalid;
			if (wr_go)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				if (wa == `ODF_OFS_CTRL)
				begin
					s_axi_bresp <= `ODF_RESP_OK;
					if (wsb[0])
						ctrl[`ODF_CTRL_EN] <= wd[`ODF_CTRL_EN];
				end
				else if (wa == `ODF_OFS_STAT || wa == `ODF_OFS_PSW)
					s_axi_bresp <= `ODF_RESP_OK;
				else
					s_axi_bresp <= `ODF_RESP_ERR;
			end
			else
			begin
				aw_got <= aw_got || aw_hs;
				w_got <= w_got || w_hs;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// sticky exception bits: write one clears, a new event wins
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ill <= 1'b0;
			st_rsvd <= 1'b0;
		end
		else if (i_ce)
		begin
			st_ill <= (st_ill && !(clr_w && wd[`ODF_STAT_ILL])) || (take && d_ill);
			st_rsvd <= (st_rsvd && !(clr_w && wd[`ODF_STAT_RSVD])) || (take && d_rsvd);
		end
	end

	// read side answers one cycle after the address is taken
	always @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ODF_RESP_OK;
		end
		else if (i_ce)
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_arready <= 1'b0;
				s_axi_rresp <= `ODF_RESP_OK;
				if (s_axi_araddr == `ODF_OFS_CTRL)
					s_axi_rdata <= ctrl;
				else if (s_axi_araddr == `ODF_OFS_PSW)
					s_axi_rdata <= processor_status_word;
				else if (s_axi_araddr == `ODF_OFS_STAT)
					s_axi_rdata <= {24'h00_0000, cur_type, 1'b0, state, st_rsvd, st_ill};
				else
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `ODF_RESP_ERR;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: verification/odf_decode_props.sv */
// assertion checker for the operand descriptor decode block
`timescale 1ns/100ps
`default_nettype none
`include "odf_decode_regs.vh"
module odf_props
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// watched inputs
	input wire logic i_desc_valid,
	input wire logic [7:0] i_desc_byte,
	input wire logic i_opnd_dst,
	input wire logic i_opc_no_expand,
	input wire logic i_raw_valid,
	input wire logic [31:0] i_raw_data,
	input wire logic [3:0] i_raw_type,
	input wire logic i_flag_valid,
	input wire logic [1:0] i_fclass,
	input wire logic [32:0] i_res,
	// watched outputs
	input wire logic o_opnd_valid,
	input wire logic [1:0] o_opnd_kind,
	input wire logic [3:0] o_opnd_reg,
	input wire logic [31:0] o_opnd_lit,
	input wire logic o_exc_illegal,
	input wire logic o_exc_rsvd,
	input wire logic o_ext_valid,
	input wire logic [31:0] o_ext_data,
	input wire logic [3:0] o_nzvc,
	input wire logic s_axi_bvalid
);
	// one clock domain, so one default clocking and disable
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	property p_lit_pos;
		o_opnd_valid && $past(i_desc_byte[7:6]) == 2'h0 |->
			o_opnd_kind == `ODF_K_LIT && o_opnd_lit == {26'h0, $past(i_desc_byte[5:0])};
	endproperty
	a_lit_pos: assert property (p_lit_pos) else $error("short literal wrong");
	property p_lit_neg;
		o_opnd_valid && $past(i_desc_byte[7:4]) == `ODF_MODE_NLIT |->
			o_opnd_lit == {24'hFFFFFF, $past(i_desc_byte)};
	endproperty
	a_lit_neg: assert property (p_lit_neg) else $error("negative literal wrong");
	property p_lit_dst;
		o_opnd_valid && $past(i_desc_byte[7:6] == 2'h0 && i_opnd_dst) |-> o_exc_illegal;
	endproperty
	a_lit_dst: assert property (p_lit_dst) else $error("literal destination passed");
	property p_reg;
		o_opnd_valid && $past(i_desc_byte[7:4]) == `ODF_MODE_REG |->
			o_opnd_kind == `ODF_K_REG && o_opnd_reg == $past(i_desc_byte[3:0]);
	endproperty
	a_reg: assert property (p_reg) else $error("register operand wrong");
	property p_ext_ub;
		$past(i_raw_valid && i_raw_type == `ODF_T_UB) |->
			o_ext_valid && o_ext_data == {24'h0, $past(i_raw_data[7:0])};
	endproperty
	a_ext_ub: assert property (p_ext_ub) else $error("byte not zero extended");
	property p_ext_sh;
		$past(i_raw_valid && i_raw_type == `ODF_T_SH) |->
			o_ext_data == {{16{$past(i_raw_data[15])}}, $past(i_raw_data[15:0])};
	endproperty
	a_ext_sh: assert property (p_ext_sh) else $error("halfword not sign extended");
	property p_rsvd;
		o_exc_rsvd |-> $past(i_desc_byte[7:4]) == `ODF_MODE_EXP &&
			$past(i_desc_byte[3:0]) inside {4'h1, 4'h5, [4'h8:4'hE]};
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved type misflagged");
	property p_noexp;
		$past(i_desc_valid && i_desc_byte[7:4] == `ODF_MODE_EXP && i_opc_no_expand) |->
			o_exc_illegal;
	endproperty
	a_noexp: assert property (p_noexp) else $error("forbidden override passed");
	property p_flag_ari;
		$past(i_flag_valid && i_fclass == `ODF_FC_ARI) |->
			o_nzvc[3] == $past(i_res[32]) && o_nzvc[2] == ($past(i_res) == 33'h0);
	endproperty
	a_flag_ari: assert property (p_flag_ari) else $error("arith n z wrong");
	property p_flag_log;
		$past(i_flag_valid && i_fclass == `ODF_FC_LOG) |-> !o_nzvc[0];
	endproperty
	a_flag_log: assert property (p_flag_log) else $error("logical carry set");
	property p_flag_tst;
		$past(i_flag_valid) && $past(i_fclass) == `ODF_FC_TST |-> !o_nzvc[1];
	endproperty
	a_flag_tst: assert property (p_flag_tst) else $error("test overflow set");
	// main scenarios seen at least once
	c_opnd: cover property (o_opnd_valid && o_opnd_kind == `ODF_K_REG);
	c_rsvd: cover property (o_exc_rsvd);
	c_bus: cover property (s_axi_bvalid);
endmodule
bind odf_decode odf_props odf_props_i (.*);
`default_nettype wire

/* File: verification/odf_fetch_model.sv */
// fetch stream model feeding descriptor bytes to the decoder
`timescale 1ns/100ps
`default_nettype none
module odf_fetch_model
(
	// clock
	input wire logic i_clk,
	// descriptor stream
	output var logic o_valid,
	output var logic [7:0] o_byte,
	output var logic o_first,
	output var logic [3:0] o_type,
	output var logic o_dst,
	output var logic o_ea,
	output var logic o_no_expand
);
	// idle stream at time zero
	initial
		{o_valid, o_byte, o_first, o_type, o_dst, o_ea, o_no_expand} = {1'b0, 8'hA5, 8'h00};
	// one beat; the byte line is inverted when idle so stale data never looks held
	task send(input [7:0] b, input f, input [3:0] t, input d, input e, input n);
		begin
			@(posedge i_clk);
			{o_valid, o_byte, o_first, o_type, o_dst, o_ea, o_no_expand} <= {1'b1, b, f, t, d, e, n};
			@(posedge i_clk);
			o_valid <= 1'b0;
			o_byte <= ~b;
		end
	endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the operand descriptor decode block
`timescale 1ns/100ps
`default_nettype none
`include "odf_decode_regs.vh"
module testbench;
	logic i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1;
	logic i_desc_valid, i_desc_first, i_opnd_dst, i_opnd_ea, i_opc_no_expand;
	logic [7:0] i_desc_byte;
	logic [3:0] i_opc_type, o_opnd_reg, o_opnd_type, o_nzvc;
	logic o_opnd_valid, o_exc_illegal, o_exc_rsvd, o_ext_valid;
	logic [1:0] o_opnd_kind, s_axi_bresp, s_axi_rresp, r;
	logic [31:0] o_opnd_lit, o_ext_data, s_axi_rdata, q;
	logic i_raw_valid = 1'b0, i_flag_valid = 1'b0, i_wfault = 1'b0;
	logic [31:0] i_raw_data = 32'h0, i_out = 32'h0, s_axi_wdata = 32'h0;
	logic [3:0] i_raw_type = 4'h0, i_dst_type = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [1:0] i_fclass = 2'h0;
	logic [32:0] i_res = 33'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] tc[6] = '{4'h7, 4'h6, 4'h4, 4'h3, 4'h2, 4'h0};
	logic [3:0] rc[9] = '{4'h1, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
	logic [31:0] xe[6] = '{32'hFFFFFFC6, 32'hFFFFA5C6, 32'h9234A5C6, 32'hC6, 32'hA5C6, 32'h9234A5C6};
	int failures = 0;
	int comparisons = 0;
	// 250 MHz clock
	always #2 i_clk = ~i_clk;
	odf_decode odf_decode_i (.*);
	odf_fetch_model odf_fetch_model_i (.i_clk(i_clk), .o_valid(i_desc_valid),
		.o_byte(i_desc_byte), .o_first(i_desc_first), .o_type(i_opc_type),
		.o_dst(i_opnd_dst), .o_ea(i_opnd_ea), .o_no_expand(i_opc_no_expand));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [63:0] got, input logic [63:0] exp);
		begin
			comparisons++;
			if (got !== exp)
			begin
				failures++;
				$display("BAD t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("comparisons %0d failures %0d", comparisons, failures);
			if (failures == 0 && comparisons > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// one register access; each channel is held until its own handshake edge
	task axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		begin
			@(posedge i_clk);
			{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
			{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
			for (n = 0; n < 50; n++)
			begin
				@(posedge i_clk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready)
				begin
					{s_axi_bready, s_axi_rready} <= 2'b00;
					q = s_axi_rdata;
					r = wr ? s_axi_bresp : s_axi_rresp;
					return;
				end
			end
			failures++;
			end_sim;
		end
	endtask
	// one descriptor; partial checks only valid and the two exceptions
	task dsc(input [7:0] b, input f, input d, input n, input full, input [12:0] e, input [31:0] lit);
		begin
			odf_fetch_model_i.send(b, f, `ODF_T_SW, d, 1'b0, n);
			#1;
			if (!full)
				chk({o_opnd_valid, o_exc_illegal, o_exc_rsvd}, {e[12], e[5:4]});
			else
				chk({o_opnd_valid, o_opnd_kind, o_opnd_type, o_exc_illegal, o_exc_rsvd, o_opnd_reg}, e);
			if (full && e[11:10] == `ODF_K_LIT)
				chk(o_opnd_lit, lit);
		end
	endtask
	task flg(input [1:0] c, input [3:0] t, input [32:0] s, input [31:0] o, input w, input [3:0] e);
		begin
			@(posedge i_clk);
			{i_flag_valid, i_fclass, i_dst_type, i_res, i_out, i_wfault} <= {1'b1, c, t, s, o, w};
			@(posedge i_clk);
			i_flag_valid <= 1'b0;
			#1;
			chk(o_nzvc, e);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		begin
			chk({o_nzvc, o_opnd_valid, o_ext_valid}, 6'h0);
			axi(1'b0, 4'h0, 32'h0);
			chk({r, q}, {2'h0, 32'h1});
			axi(1'b1, 4'h4, 32'hFFFFFFFF);
			chk(r, 2'h0);
			axi(1'b0, 4'h4, 32'h0);
			chk(q, 32'h0);
			axi(1'b1, 4'hC, 32'h1);
			chk(r, 2'h2);
			axi(1'b0, 4'hC, 32'h0);
			chk({r, q}, {2'h2, 32'h0});
			$display("register test done");
		end
	endtask
	task t_desc;
		begin
			dsc(8'h04, 1, 0, 0, 1, {1'b1, `ODF_K_LIT, 4'h4, 2'b00, 4'h4}, 32'h4);
			dsc(8'h3F, 1, 0, 0, 1, {1'b1, `ODF_K_LIT, 4'h4, 2'b00, 4'hF}, 32'h3F);
			dsc(8'hFF, 1, 0, 0, 1, {1'b1, `ODF_K_LIT, 4'h4, 2'b00, 4'hF}, 32'hFFFFFFFF);
			dsc(8'hF0, 1, 0, 0, 1, {1'b1, `ODF_K_LIT, 4'h4, 2'b00, 4'h0}, 32'hFFFFFFF0);
			dsc(8'h04, 1, 1, 0, 1, {1'b1, `ODF_K_LIT, 4'h4, 2'b10, 4'h4}, 32'h4);
			dsc(8'h4E, 1, 0, 0, 1, {1'b1, `ODF_K_REG, 4'h4, 2'b00, 4'hE}, 32'h0);
			dsc(8'h5C, 1, 0, 0, 1, {1'b1, `ODF_K_DEF, 4'h4, 2'b00, 4'hC}, 32'h0);
			foreach (tc[k])
			begin
				dsc({4'hE, tc[k]}, 1, 0, 0, 0, 13'h0000, 32'h0);
				dsc(8'h40, 0, 0, 0, 1, {1'b1, `ODF_K_REG, tc[k], 6'h0}, 32'h0);
			end
			dsc(8'h41, 0, 0, 0, 1, {1'b1, `ODF_K_REG, 4'h0, 2'b00, 4'h1}, 32'h0);
			dsc(8'hE2, 0, 0, 0, 0, 13'h0000, 32'h0);
			dsc(8'hC1, 0, 0, 0, 1, {1'b1, `ODF_K_OTH, 4'h2, 2'b00, 4'h1}, 32'h0);
			dsc(8'h42, 1, 0, 0, 1, {1'b1, `ODF_K_REG, 4'h4, 2'b00, 4'h2}, 32'h0);
			foreach (rc[k])
			begin
				dsc({4'hE, rc[k]}, 1, 0, 0, 0, 13'h0010, 32'h0);
				dsc(8'h41, 0, 0, 0, 0, 13'h1000, 32'h0);
			end
			dsc(8'hE7, 1, 0, 1, 0, 13'h0020, 32'h0);
			dsc(8'h40, 0, 0, 1, 0, 13'h1000, 32'h0);
			$display("descriptor test done");
		end
	endtask
	task t_ext;
		begin
			foreach (tc[k])
			begin
				@(posedge i_clk);
				{i_raw_valid, i_raw_data, i_raw_type} <= {1'b1, 32'h9234A5C6, tc[k]};
				@(posedge i_clk);
				i_raw_valid <= 1'b0;
				#1;
				chk({o_ext_valid, o_ext_data}, {1'b1, xe[k]});
			end
			$display("extension test done");
		end
	endtask
	task t_flags;
		begin
			flg(`ODF_FC_LOG, 4'h3, 33'h80, 32'h80, 0, 4'h8);
			flg(`ODF_FC_LOG, 4'h4, 33'h0, 32'h0, 0, 4'h4);
			flg(`ODF_FC_ARI, 4'h0, 33'h100000000, 32'h0, 0, 4'hB);
			flg(`ODF_FC_ARI, 4'h7, 33'h80, 32'h80, 0, 4'h2);
			flg(`ODF_FC_TST, 4'h6, 33'h1FFFF8000, 32'h8000, 0, 4'h9);
			flg(`ODF_FC_ARI, 4'h2, 33'h1FFFFFFFF, 32'hFFFF, 1, 4'hB);
			flg(`ODF_FC_ALS, 4'h4, 33'h80000000, 32'h80000000, 0, 4'h2);
			axi(1'b0, 4'h4, 32'h0);
			chk(q, {10'h0, 4'h2, 18'h0});
			$display("flag test done");
		end
	endtask
	// address-taking opcodes, bad registers, double override, status, enables
	task t_misc;
		begin
			odf_fetch_model_i.send(8'h04, 1, `ODF_T_SW, 0, 1, 0);
			#1;
			chk({o_opnd_valid, o_exc_illegal}, 2'b11);
			odf_fetch_model_i.send(8'h41, 1, `ODF_T_SW, 0, 1, 0);
			#1;
			chk({o_opnd_valid, o_exc_illegal}, 2'b11);
			dsc(8'h4F, 1, 0, 0, 0, 13'h1020, 32'h0);
			dsc(8'h5B, 1, 0, 0, 1, {1'b1, `ODF_K_DEF, 4'h4, 2'b10, 4'hB}, 32'h0);
			dsc(8'hE6, 1, 0, 0, 0, 13'h0000, 32'h0);
			dsc(8'hE3, 0, 0, 0, 1, {1'b1, `ODF_K_OTH, 4'h6, 2'b10, 4'h3}, 32'h0);
			// sticky bits are still set from the earlier scenarios
			axi(1'b0, 4'h8, 32'h0);
			chk({r, q}, {2'h0, 32'h63});
			axi(1'b1, 4'h8, 32'h3);
			chk(r, 2'h0);
			axi(1'b0, 4'h8, 32'h0);
			chk(q, 32'h60);
			dsc(8'hE7, 1, 0, 0, 0, 13'h0000, 32'h0);
			axi(1'b0, 4'h8, 32'h0);
			chk(q, 32'h74);
			dsc(8'h3F, 0, 0, 0, 1, {1'b1, `ODF_K_LIT, 4'h7, 2'b00, 4'hF}, 32'h3F);
			// a byte offered while the clock enable is low must leave no trace
			@(posedge i_clk);
			i_ce <= 1'b0;
			odf_fetch_model_i.send(8'h4A, 1, `ODF_T_SW, 0, 0, 0);
			#1;
			chk({o_opnd_valid, o_opnd_reg}, {1'b0, 4'hF});
			@(posedge i_clk);
			i_ce <= 1'b1;
			// decode switched off in the control register ignores bytes
			axi(1'b1, 4'h0, 32'h0);
			dsc(8'h41, 1, 0, 0, 0, 13'h0000, 32'h0);
			axi(1'b0, 4'h0, 32'h0);
			chk({r, q}, {2'h0, 32'h0});
			axi(1'b1, 4'h0, 32'h1);
			chk(r, 2'h0);
			$display("mixed decode test done");
		end
	endtask
	// reset for 16 cycles, then the scenarios
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_clk);
		t_regs;
		t_desc;
		t_ext;
		t_flags;
		t_misc;
		end_sim;
	end
endmodule
`default_nettype wire
